// ===== hw/atb_bridge.sv
// Task file bridge: host register port to PIO cycles on the IDE interface
//
// Added by the designer: strobed register access.
`include "atb_map.svh"
// Behaviour
// - Host accesses to task file registers become PIO cycles of the matching drive register; command reads, first data bytes and accesses while busy do not.
// - Address 40h reaches drive register 1F0 with control select high and command select and address low.
// - Register 1F0 is reached by two consecutive byte accesses, low byte first, then one 16-bit PIO cycle.
// - Address 48h reaches error/feature with control select high, command select low, address 001.
// - Address 49h reaches sector count with control select high, command select low, address 010.
// - Address 4Ah reaches sector number with control select high, command select low, address 011.
// - Address 4Bh reaches cylinder low with control select high, command select low, address 100.
// - Address 4Ch reaches cylinder high with control select high, command select low, address 101.
// - Address 4Dh reaches drive/head with control select high, command select low, address 110.
// - A write to 44h goes to the command register with control select high, command select low, address 111.
// - The command register is write-only and a host read of it returns FFh.
// - Address 4Eh reaches alternate status with control select low, command select high, address 110.
// - Address 4Fh reaches drive address with control select low, command select high, address 111.
module atb_bridge (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic usb_bus_reset,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // IDE data bus
   input wire logic [15:0] ide_data_in,
   output logic [15:0] ide_data_out,
   output logic ide_data_oe,
   // IDE strobes and register selection
   output logic ide_read_strobe_n,
   output logic ide_write_strobe_n,
   output logic control_block_select_n,
   output logic command_block_select_n,
   output logic device_addr_bit2,
   output logic device_addr_bit1,
   output logic device_addr_bit0,
   // Status
   output logic pio_busy
);
   import atb_pkg::*;

   function automatic atb_sel_t sel_of(input logic [7:0] addr);
      atb_sel_t s;
      s = `ATB_SEL_IDLE;
      if (addr == `ATB_OFF_DATA) begin
         s = `ATB_SEL_DATA;
      end else if (addr == `ATB_OFF_ERR) begin
         s = `ATB_SEL_ERR;
      end else if (addr == `ATB_OFF_CNT) begin
         s = `ATB_SEL_CNT;
      end else if (addr == `ATB_OFF_SNUM) begin
         s = `ATB_SEL_SNUM;
      end else if (addr == `ATB_OFF_CYLL) begin
         s = `ATB_SEL_CYLL;
      end else if (addr == `ATB_OFF_CYLH) begin
         s = `ATB_SEL_CYLH;
      end else if (addr == `ATB_OFF_DRV) begin
         s = `ATB_SEL_DRV;
      end else if (addr == `ATB_OFF_CMD) begin
         s = `ATB_SEL_CMD;
      end else if (addr == `ATB_OFF_ALT) begin
         s = `ATB_SEL_ALT;
      end else if (addr == `ATB_OFF_DADDR) begin
         s = `ATB_SEL_DADDR;
      end
      return s;
   endfunction : sel_of

   // Byte-wide task file positions, held in the shadow memory
   function automatic logic is_byte_reg(input logic [7:0] addr);
      logic hit;
      hit = 1'b0;
      if (addr == `ATB_OFF_CMD) begin
         hit = 1'b1;
      end else if ((addr >= `ATB_OFF_ERR) && (addr <= `ATB_OFF_DADDR)) begin
         hit = 1'b1;
      end
      return hit;
   endfunction : is_byte_reg

   atb_main_s q;
   atb_main_s n;
   atb_pio_if pio ();
   logic [4:0] ide_sel;
   logic busy;
   logic mem_clear;
   logic mem_we;
   logic [3:0] mem_waddr;
   logic [7:0] mem_wdata;
   logic [7:0] mem_rdata;

   always_comb begin
      n = q;
      n.go = 1'b0;
      n.from_mem = 1'b0;
      n.rdata = `ATB_REG_RST;
      mem_clear = usb_bus_reset;
      mem_we = 1'b0;
      mem_waddr = reg_addr[3:0];
      mem_wdata = reg_wdata;
      // Engine stays owned through its done cycle so a refresh never meets a host write
      busy = pio.busy || q.go || pio.done;

      // Refresh the shadow copy with what the drive returned
      if (pio.done && q.pend_rd) begin
         n.pend_rd = 1'b0;
         if (q.pend_data) begin
            n.data_rd = pio.rdata;
         end else begin
            mem_we = 1'b1;
            mem_waddr = q.pend_idx;
            mem_wdata = pio.rdata[7:0];
         end
      end

      if (reg_wr) begin
         if (reg_addr == `ATB_OFF_DATA) begin
            if (q.phase && q.phase_wr) begin
               n.phase = 1'b0;
               if (busy) begin
                  n.overrun = 1'b1;
               end else begin
                  n.go = 1'b1;
                  n.go_wr = 1'b1;
                  n.go_sel = sel_of(reg_addr);
                  n.go_wdata = {reg_wdata, q.lo_byte};
               end
            end else begin
               n.lo_byte = reg_wdata;
               n.phase = 1'b1;
               n.phase_wr = 1'b1;
            end
         end else begin
            n.phase = 1'b0;
            if (is_byte_reg(reg_addr)) begin
               if (busy) begin
                  n.overrun = 1'b1;
               end else begin
                  // Command goes out as it stands; ordering is up to software
                  mem_we = 1'b1;
                  mem_waddr = reg_addr[3:0];
                  mem_wdata = reg_wdata;
                  n.go = 1'b1;
                  n.go_wr = 1'b1;
                  n.go_sel = sel_of(reg_addr);
                  n.go_wdata = {8'h00, reg_wdata};
               end
            end else if (reg_addr == `ATB_OFF_CTRL) begin
               n.strobe_len = reg_wdata;
            end else if (reg_addr == `ATB_OFF_STAT) begin
               if (reg_wdata[`ATB_STAT_OVERRUN]) begin
                  n.overrun = 1'b0;
               end
            end
         end
      end else if (reg_rd) begin
         if (reg_addr == `ATB_OFF_DATA) begin
            if (q.phase && !q.phase_wr) begin
               n.rdata = q.data_rd[15:8];
               n.phase = 1'b0;
               if (busy) begin
                  n.overrun = 1'b1;
               end else begin
                  // Second byte read prefetches the next word from the drive
                  n.go = 1'b1;
                  n.go_wr = 1'b0;
                  n.go_sel = sel_of(reg_addr);
                  n.pend_rd = 1'b1;
                  n.pend_data = 1'b1;
               end
            end else begin
               n.rdata = q.data_rd[7:0];
               n.phase = 1'b1;
               n.phase_wr = 1'b0;
            end
         end else if (reg_addr == `ATB_OFF_CMD) begin
            n.phase = 1'b0;
            n.rdata = `ATB_CMD_READ_VAL;
         end else if (is_byte_reg(reg_addr)) begin
            n.phase = 1'b0;
            n.from_mem = 1'b1;
            if (busy) begin
               n.overrun = 1'b1;
            end else begin
               n.go = 1'b1;
               n.go_wr = 1'b0;
               n.go_sel = sel_of(reg_addr);
               n.pend_rd = 1'b1;
               n.pend_data = 1'b0;
               n.pend_idx = reg_addr[3:0];
            end
         end else if (reg_addr == `ATB_OFF_CTRL) begin
            n.phase = 1'b0;
            n.rdata = q.strobe_len;
         end else if (reg_addr == `ATB_OFF_STAT) begin
            n.phase = 1'b0;
            n.rdata[`ATB_STAT_BUSY] = busy;
            n.rdata[`ATB_STAT_OVERRUN] = q.overrun;
            n.rdata[`ATB_STAT_PHASE] = q.phase;
         end else begin
            n.phase = 1'b0;
         end
      end

      // Bus reset wipes the data word and any refresh still on its way
      if (usb_bus_reset) begin
         n.data_rd = 16'h0000;
         n.lo_byte = `ATB_REG_RST;
         n.phase = 1'b0;
         n.pend_rd = 1'b0;
         n.from_mem = 1'b0;
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         q <= '0;
         q.go_sel <= `ATB_SEL_IDLE;
         q.strobe_len <= 8'(`ATB_STROBE_CYC);
      end else begin
         q <= n;
      end
   end

   // Engine request side
   assign pio.req = q.go;
   assign pio.wr = q.go_wr;
   assign pio.sel = q.go_sel;
   assign pio.wdata = q.go_wdata;
   assign pio.strobe_len = q.strobe_len;

   atb_pio_engine u_engine (
      .ref_clk(ref_clk),
      .reset(reset),
      .pio(pio.eng),
      .ide_data_in(ide_data_in),
      .ide_data_out(ide_data_out),
      .ide_data_oe(ide_data_oe),
      .ide_read_strobe_n(ide_read_strobe_n),
      .ide_write_strobe_n(ide_write_strobe_n),
      .ide_sel(ide_sel)
   );

   atb_shadow_mem u_shadow (
      .ref_clk(ref_clk),
      .reset(reset),
      .clear(mem_clear),
      .we(mem_we),
      .waddr(mem_waddr),
      .wdata(mem_wdata),
      .raddr(reg_addr[3:0]),
      .rdata(mem_rdata)
   );

   // Both sources are registers, so the read data stand for exactly the one cycle
   assign reg_rdata = q.from_mem ? mem_rdata : q.rdata;
   assign control_block_select_n = ide_sel[4];
   assign command_block_select_n = ide_sel[3];
   assign device_addr_bit2 = ide_sel[2];
   assign device_addr_bit1 = ide_sel[1];
   assign device_addr_bit0 = ide_sel[0];
   assign pio_busy = busy;
endmodule : atb_bridge

// ===== hw/atb_map.svh
// Offsets, select codes, reset values and timing counts of the task file bridge
`ifndef ATB_MAP_SVH
`define ATB_MAP_SVH
`define ATB_CLK_PERIOD_NS 10
`define ATB_SETUP_NS 70
`define ATB_HOLD_NS 30
`define ATB_STROBE_NS 165
`define ATB_SETUP_CYC ((`ATB_SETUP_NS + `ATB_CLK_PERIOD_NS - 1) / `ATB_CLK_PERIOD_NS)
`define ATB_HOLD_CYC ((`ATB_HOLD_NS + `ATB_CLK_PERIOD_NS - 1) / `ATB_CLK_PERIOD_NS)
`define ATB_STROBE_CYC ((`ATB_STROBE_NS + `ATB_CLK_PERIOD_NS - 1) / `ATB_CLK_PERIOD_NS)
`define ATB_OFF_DATA 8'h40
`define ATB_OFF_CMD 8'h44
`define ATB_OFF_ERR 8'h48
`define ATB_OFF_CNT 8'h49
`define ATB_OFF_SNUM 8'h4a
`define ATB_OFF_CYLL 8'h4b
`define ATB_OFF_CYLH 8'h4c
`define ATB_OFF_DRV 8'h4d
`define ATB_OFF_ALT 8'h4e
`define ATB_OFF_DADDR 8'h4f
`define ATB_OFF_CTRL 8'h58
`define ATB_OFF_STAT 8'h5c
`define ATB_SEL_IDLE 5'h18
`define ATB_SEL_DATA 5'h10
`define ATB_SEL_ERR 5'h11
`define ATB_SEL_CNT 5'h12
`define ATB_SEL_SNUM 5'h13
`define ATB_SEL_CYLL 5'h14
`define ATB_SEL_CYLH 5'h15
`define ATB_SEL_DRV 5'h16
`define ATB_SEL_CMD 5'h17
`define ATB_SEL_ALT 5'h0e
`define ATB_SEL_DADDR 5'h0f
`define ATB_CMD_READ_VAL 8'hff
`define ATB_REG_RST 8'h00
`define ATB_STAT_BUSY 0
`define ATB_STAT_OVERRUN 1
`define ATB_STAT_PHASE 2
`endif

// ===== hw/atb_pio_engine.sv
// PIO cycle engine driving selects, address lines, strobes and data on the IDE pins
`include "atb_map.svh"
module atb_pio_engine (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Requests from the bridge
   atb_pio_if.eng pio,
   // IDE pins
   input wire logic [15:0] ide_data_in,
   output logic [15:0] ide_data_out,
   output logic ide_data_oe,
   output logic ide_read_strobe_n,
   output logic ide_write_strobe_n,
   output logic [4:0] ide_sel
);
   import atb_pkg::*;
   localparam logic [7:0] SETUP_CYC = 8'(`ATB_SETUP_CYC);
   localparam logic [7:0] HOLD_CYC = 8'(`ATB_HOLD_CYC);
   atb_eng_s q;
   atb_eng_s n;
   always_comb begin
      n = q;
      n.done = 1'b0;
      n.s1 = ide_data_in;
      n.s2 = q.s1;
      n.s3 = q.s2;
      // A data change counts only once two stages agree
      if (q.s2 == q.s3) begin
         n.filt = q.s3;
      end
      case (q.st)
         eng_idle: begin
            if (pio.req) begin
               n.st = eng_setup;
               n.cnt = SETUP_CYC;
               n.wr = pio.wr;
               n.sel = pio.sel;
               n.wdata = pio.wdata;
            end
         end
         eng_setup: begin
            if (q.cnt <= 8'h01) begin
               n.st = eng_strobe;
               n.cnt = (pio.strobe_len == 8'h00) ? 8'h01 : pio.strobe_len;
            end else begin
               n.cnt = q.cnt - 8'h01;
            end
         end
         eng_strobe: begin
            if (q.cnt <= 8'h01) begin
               n.st = eng_hold;
               n.cnt = HOLD_CYC;
               // Filter lags the pins by four cycles, so short strobes read stale data
               if (!q.wr) begin
                  n.rdata = q.filt;
               end
            end else begin
               n.cnt = q.cnt - 8'h01;
            end
         end
         eng_hold: begin
            if (q.cnt <= 8'h01) begin
               n.st = eng_idle;
               n.sel = `ATB_SEL_IDLE;
               n.wr = 1'b0;
               n.done = 1'b1;
            end else begin
               n.cnt = q.cnt - 8'h01;
            end
         end
         default: begin
            n.st = eng_idle;
         end
      endcase
   end
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         q <= '0;
         q.sel <= `ATB_SEL_IDLE;
      end else begin
         q <= n;
      end
   end
   assign pio.busy = (q.st != eng_idle);
   assign pio.done = q.done;
   assign pio.rdata = q.rdata;
   assign ide_sel = q.sel;
   assign ide_data_out = q.wdata;
   assign ide_data_oe = q.wr && (q.st != eng_idle);
   assign ide_read_strobe_n = !((q.st == eng_strobe) && !q.wr);
   assign ide_write_strobe_n = !((q.st == eng_strobe) && q.wr);
endmodule : atb_pio_engine

// ===== hw/atb_pio_if.sv
// Request and answer signals between the bridge and its PIO cycle engine
interface atb_pio_if;
   logic req;
   logic wr;
   atb_pkg::atb_sel_t sel;
   logic [15:0] wdata;
   logic [7:0] strobe_len;
   logic busy;
   logic done;
   logic [15:0] rdata;
   modport ctl (output req, output wr, output sel, output wdata, output strobe_len,
                input busy, input done, input rdata);
   modport eng (input req, input wr, input sel, input wdata, input strobe_len,
                output busy, output done, output rdata);
endinterface : atb_pio_if

// ===== hw/atb_pkg.sv
// Types shared by the task file bridge modules
package atb_pkg;
   typedef enum logic [1:0] {eng_idle, eng_setup, eng_strobe, eng_hold} atb_eng_e;
   typedef logic [4:0] atb_sel_t;
   typedef struct packed {
      atb_eng_e st;
      logic [7:0] cnt;
      logic wr;
      atb_sel_t sel;
      logic [15:0] wdata;
      logic [15:0] rdata;
      logic done;
      logic [15:0] s1;
      logic [15:0] s2;
      logic [15:0] s3;
      logic [15:0] filt;
   } atb_eng_s;
   typedef struct packed {
      logic [15:0][7:0] words;
      logic [7:0] rdata;
   } atb_mem_s;
   typedef struct packed {
      logic phase;
      logic phase_wr;
      logic [7:0] lo_byte;
      logic [15:0] data_rd;
      logic [7:0] strobe_len;
      logic overrun;
      logic go;
      logic go_wr;
      atb_sel_t go_sel;
      logic [15:0] go_wdata;
      logic pend_rd;
      logic pend_data;
      logic [3:0] pend_idx;
      logic from_mem;
      logic [7:0] rdata;
   } atb_main_s;
endpackage : atb_pkg

// ===== hw/atb_shadow_mem.sv
// Shadow copies of the byte-wide task file registers, registered read port
module atb_shadow_mem (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Clear and write port
   input wire logic clear,
   input wire logic we,
   input wire logic [3:0] waddr,
   input wire logic [7:0] wdata,
   // Read port
   input wire logic [3:0] raddr,
   output logic [7:0] rdata
);
   import atb_pkg::*;
   atb_mem_s q;
   atb_mem_s n;
   always_comb begin
      n = q;
      n.rdata = q.words[raddr];
      if (clear) begin
         n.words = '0;
      end else if (we) begin
         n.words[waddr] = wdata;
      end
   end
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end
   assign rdata = q.rdata;
endmodule : atb_shadow_mem

// ===== sim/atb_bridge_assertions.sv
// Concurrent checks on the ports of the task file bridge
module atb_bridge_assertions (
   // Clock and resets
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic usb_bus_reset,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // IDE side
   input wire logic [15:0] ide_data_in,
   input wire logic [15:0] ide_data_out,
   input wire logic ide_data_oe,
   input wire logic ide_read_strobe_n,
   input wire logic ide_write_strobe_n,
   input wire logic control_block_select_n,
   input wire logic command_block_select_n,
   input wire logic device_addr_bit2,
   input wire logic device_addr_bit1,
   input wire logic device_addr_bit0,
   input wire logic pio_busy
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [4:0] sel;
   logic byte_acc;
   logic lo_seen_q, lo_seen_d;
   logic [7:0] lo_byte_q, lo_byte_d;
   function automatic logic [4:0] sel_of(input logic [7:0] a);
      case (a)
         8'h4e: sel_of = 5'h0e;
         8'h4f: sel_of = 5'h0f;
         8'h44: sel_of = 5'h17;
         default: sel_of = {2'b10, a[2:0] + 3'h1};
      endcase
   endfunction : sel_of
   assign sel = {control_block_select_n, command_block_select_n, device_addr_bit2, device_addr_bit1, device_addr_bit0};
   assign byte_acc = reg_addr inside {[8'h48:8'h4f]};
   // Any access other than a write of the data port breaks a pending byte pair
   always_comb begin
      lo_seen_d = lo_seen_q;
      lo_byte_d = lo_byte_q;
      if (usb_bus_reset) begin
         lo_seen_d = 1'b0;
      end else if (reg_wr && reg_addr == 8'h40 && !lo_seen_q) begin
         lo_seen_d = 1'b1;
         lo_byte_d = reg_wdata;
      end else if (reg_wr || reg_rd) begin
         lo_seen_d = 1'b0;
      end
   end
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         lo_seen_q <= 1'b0;
         lo_byte_q <= 8'h00;
      end else begin
         lo_seen_q <= lo_seen_d;
         lo_byte_q <= lo_byte_d;
      end
   end
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);
   chk_idle_pins: assert property (
      !pio_busy |-> sel == 5'h18 && ide_read_strobe_n && ide_write_strobe_n && !ide_data_oe)
      else $error("pins not idle without a PIO cycle");
   chk_strobe_sel: assert property (
      !(ide_read_strobe_n && ide_write_strobe_n) |-> (ide_read_strobe_n || ide_write_strobe_n)
      && (control_block_select_n != command_block_select_n))
      else $error("strobe without a single block select");
   chk_byte_sel: assert property (
      (reg_wr || reg_rd) && byte_acc && !pio_busy |-> ##2 sel == sel_of($past(reg_addr, 2)))
      else $error("wrong selects for a byte register");
   chk_cmd_sel: assert property (
      reg_wr && reg_addr == 8'h44 && !pio_busy |-> ##2 sel == 5'h17 && ide_data_oe)
      else $error("wrong selects for the command write");
   chk_byte_wdata: assert property (
      reg_wr && (byte_acc || reg_addr == 8'h44) && !pio_busy |-> ##2 ide_data_out == {8'h00, $past(reg_wdata, 2)})
      else $error("byte write data not on the pins");
   chk_cmd_rd_ff: assert property (reg_rd && reg_addr == 8'h44 |=> reg_rdata == 8'hff)
      else $error("command read not FFh");
   chk_cmd_rd_quiet: assert property (reg_rd && reg_addr == 8'h44 && !pio_busy |=> !pio_busy)
      else $error("command read started a PIO cycle");
   chk_data_lo_wait: assert property (reg_wr && reg_addr == 8'h40 && !lo_seen_q && !pio_busy |=> !pio_busy)
      else $error("low data byte started a PIO cycle");
   chk_data_pair: assert property (
      reg_wr && reg_addr == 8'h40 && lo_seen_q && !pio_busy
      |-> ##2 sel == 5'h10 && ide_data_out == {$past(reg_wdata, 2), $past(lo_byte_q, 2)})
      else $error("data word or selects wrong");
   chk_setup_len: assert property ($rose(ide_data_oe) |-> ide_write_strobe_n [*7] ##1 !ide_write_strobe_n)
      else $error("write setup not seven cycles");
   chk_hold_len: assert property ($rose(ide_write_strobe_n) |-> ide_data_oe [*3] ##1 !ide_data_oe)
      else $error("write hold not three cycles");
   chk_bus_rst_zero: assert property (usb_bus_reset ##1 (reg_rd && byte_acc) |=> reg_rdata == 8'h00)
      else $error("register not cleared by bus reset");
endmodule : atb_bridge_assertions
bind atb_bridge atb_bridge_assertions chk (.ref_clk, .reset, .usb_bus_reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
   .reg_rdata, .ide_data_in, .ide_data_out, .ide_data_oe, .ide_read_strobe_n, .ide_write_strobe_n,
   .control_block_select_n, .command_block_select_n, .device_addr_bit2, .device_addr_bit1, .device_addr_bit0, .pio_busy);

// ===== sim/atb_drive_model.sv
// Behavioural drive answering PIO cycles on the IDE pins
module atb_drive_model (
   // Clock and pace
   input wire logic ref_clk,
   input wire logic slow,
   // IDE pins from the bridge
   input wire logic [4:0] sel,
   input wire logic ide_read_strobe_n,
   input wire logic ide_write_strobe_n,
   input wire logic ide_data_oe,
   input wire logic [15:0] ide_data_out,
   // Answer and record of the last write
   output logic [15:0] ide_data_in,
   output logic [4:0] last_sel,
   output logic [15:0] last_wdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] mem [16];
   logic [3:0] idx;
   int rd_cyc;
   assign idx = {~sel[4], sel[2:0]};
   initial begin
      foreach (mem[i]) begin
         mem[i] = 16'h0000;
      end
      ide_data_in = 16'h0000;
      rd_cyc = 0;
   end
   // The write is taken as the strobe ends, while selects and data still stand
   always @(posedge ide_write_strobe_n) begin
      if (ide_data_oe === 1'b1) begin
         mem[idx] <= ide_data_out;
         last_sel <= sel;
         last_wdata <= ide_data_out;
      end
   end
   // No pull on the bus: outside a read the lines flip every cycle
   always @(posedge ref_clk) begin
      if (!ide_read_strobe_n) begin
         rd_cyc <= rd_cyc + 1;
         ide_data_in <= (slow && rd_cyc < 3) ? ~ide_data_in : mem[idx];
      end else begin
         rd_cyc <= 0;
         ide_data_in <= ~ide_data_in;
      end
   end
endmodule : atb_drive_model

// ===== sim/tb_atb_bridge.sv
// Self-checking bench of the task file bridge
module tb_atb_bridge;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk, reset, usb_bus_reset, reg_wr, reg_rd, slow;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
   logic [15:0] ide_data_in, ide_data_out, last_wdata;
   logic ide_data_oe, ide_read_strobe_n, ide_write_strobe_n, pio_busy;
   logic control_block_select_n, command_block_select_n, device_addr_bit2, device_addr_bit1, device_addr_bit0;
   logic [4:0] sel, last_sel;
   int tests_run = 0;
   int miscompares = 0;
   logic [7:0] addr_tab [10] = '{8'h48, 8'h49, 8'h4a, 8'h4b, 8'h4c, 8'h4d, 8'h4e, 8'h4f, 8'h44, 8'h40};
   logic [4:0] sel_tab [8] = '{5'h11, 5'h12, 5'h13, 5'h14, 5'h15, 5'h16, 5'h0e, 5'h0f};
   assign sel = {control_block_select_n, command_block_select_n, device_addr_bit2, device_addr_bit1, device_addr_bit0};
   atb_bridge uut (.ref_clk, .reset, .usb_bus_reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .ide_data_in, .ide_data_out, .ide_data_oe, .ide_read_strobe_n, .ide_write_strobe_n, .control_block_select_n,
      .command_block_select_n, .device_addr_bit2, .device_addr_bit1, .device_addr_bit0, .pio_busy);
   atb_drive_model drv (.ref_clk, .slow, .sel, .ide_read_strobe_n, .ide_write_strobe_n, .ide_data_oe,
      .ide_data_out, .ide_data_in, .last_sel, .last_wdata);
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      #1;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask : rd
   // Bounded wait, so a stuck engine shows as a mismatch and not a hang
   task automatic wait_idle;
      int n;
      n = 0;
      while (pio_busy !== 1'b0 && n < 300) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      check("pio_busy idle", 16'(pio_busy), 16'h0000);
   endtask : wait_idle
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : stop_test
   initial begin
      #200000;
      miscompares++;
      stop_test();
   end
   initial begin
      reset = 1'b1;
      usb_bus_reset = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      slow = 1'b0;
      repeat (16) @(posedge ref_clk);
      reset <= 1'b0;
      for (int i = 0; i < 10; i++) begin
         rd(addr_tab[i], v);
         check("reset value", 16'(v), (i == 8) ? 16'h00ff : 16'h0000);
         wait_idle();
      end
      // Read straight after each write lands while the write still runs
      for (int i = 0; i < 8; i++) begin
         wr(addr_tab[i], addr_tab[i] ^ 8'ha5);
         rd(addr_tab[i], v);
         check("shadow", 16'(v), 16'(addr_tab[i] ^ 8'ha5));
         wait_idle();
         check("select", 16'(last_sel), 16'(sel_tab[i]));
         check("write data", last_wdata, 16'(addr_tab[i] ^ 8'ha5));
      end
      // Reads refused during the writes above must have left the overrun flag up
      rd(8'h5c, v);
      check("overrun set", 16'(v), 16'h0002);
      wr(8'h5c, 8'h02);
      rd(8'h5c, v);
      check("overrun clear", 16'(v), 16'h0000);
      rd(8'h58, v);
      check("strobe length", 16'(v), 16'h0011);
      slow <= 1'b1;
      drv.mem[2] = 16'h003c;
      rd(8'h49, v);
      check("old count", 16'(v), 16'h00ec);
      wait_idle();
      rd(8'h49, v);
      check("refreshed count", 16'(v), 16'h003c);
      wait_idle();
      slow <= 1'b0;
      wr(8'h40, 8'h34);
      check("busy after low byte", 16'(pio_busy), 16'h0000);
      wr(8'h40, 8'h12);
      wait_idle();
      check("data select", 16'(last_sel), 16'h0010);
      check("data word", last_wdata, 16'h1234);
      drv.mem[0] = 16'habcd;
      rd(8'h40, v);
      rd(8'h40, v);
      wait_idle();
      rd(8'h40, v);
      check("data low", 16'(v), 16'h00cd);
      rd(8'h40, v);
      check("data high", 16'(v), 16'h00ab);
      wait_idle();
      wr(8'h44, 8'hec);
      wait_idle();
      check("command select", 16'(last_sel), 16'h0017);
      check("command data", last_wdata, 16'h00ec);
      rd(8'h44, v);
      check("command read", 16'(v), 16'h00ff);
      check("command read quiet", 16'(pio_busy), 16'h0000);
      rd(8'h20, v);
      check("unmapped", 16'(v), 16'h0000);
      @(posedge ref_clk);
      usb_bus_reset <= 1'b1;
      @(posedge ref_clk);
      usb_bus_reset <= 1'b0;
      reg_rd <= 1'b1;
      reg_addr <= 8'h48;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      check("bus reset first", 16'(reg_rdata), 16'h0000);
      for (int i = 1; i < 10; i++) begin
         rd(addr_tab[i], v);
         check("bus reset value", 16'(v), (i == 8) ? 16'h00ff : 16'h0000);
      end
      wait_idle();
      stop_test();
   end
endmodule : tb_atb_bridge
